/* rtl/ubg_baud_gen.sv */
// Baud-rate generator top: register port, divider chain, baud timer, interrupt
//
// Operation
// - Baud timer counts down, ticked by divider output if enabled, else prescaler.
// - In fractional mode the run bit starts and stops the baud timer.
// - Underflow reloads timer from 8-bit reload value and emits one pulse.
// - Enabled divider in normal mode halts baud timer, run bit ignored.
// - Peripheral clock divided by two to the prescale select field.
// - Fractional mode scales clock by increment over 256; normal mode reloads its counter from increment.
// - Baud pulse every reload value plus one timer clocks.
// - All baud generation derives from the peripheral clock through the prescaler.
// - Normal mode runs 8-bit up-counter from increment; count readable as result.
// - Normal-mode overflow sets divider overflow flag and requests interrupt.
// - Normal mode outputs one pulse per 256 minus increment input clocks.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ns
`include "ubg_map.svh"

module ubg_baud_gen #(
    parameter int ADDR_W   = 8,
    parameter int DATA_W   = 32,
    parameter int PRESEL_W = 3,
    parameter int RELOAD_W = 8
) (
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWrData,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [DATA_W-1:0] regRdData,
    output logic                   baudPulse,
    output logic                   dividedClock,
    output logic                   irq
);

    // ========================================================================
    // Elaboration checks
    generate
        if (ADDR_W < 8) begin : g_bad_addr
            $error("ubg_baud_gen: ADDR_W must be at least 8");
        end
        if (DATA_W < 16) begin : g_bad_data
            $error("ubg_baud_gen: DATA_W must be at least 16");
        end
        if (PRESEL_W != 3) begin : g_bad_presel
            $error("ubg_baud_gen: the prescale select field is 3 bits wide");
        end
        if (RELOAD_W != 8) begin : g_bad_reload
            $error("ubg_baud_gen: the baud reload field is 8 bits wide");
        end
    endgenerate

    // ========================================================================
    // Helper functions
    // Full-address match of a register offset
    function automatic logic regHit(input logic [ADDR_W-1:0] addr,
                                    input logic [7:0]        ofs);
        regHit = (addr == ADDR_W'(ofs));
    endfunction : regHit

    // Sticky bits: set wins over write-one-clear
    function automatic logic [1:0] stickyNext(input logic [1:0] cur,
                                              input logic [1:0] clr,
                                              input logic [1:0] set);
        stickyNext = (cur & ~clr) | set;
    endfunction : stickyNext

    // Zero-extend a byte
    function automatic logic [DATA_W-1:0] ext8(input logic [7:0] v);
        ext8 = {{(DATA_W-8){1'b0}}, v};
    endfunction : ext8

    // ========================================================================
    // Control registers
    ubg_pkg::ubg_ctrl_t   ctrl_r;
    ubg_pkg::ubg_ctrl_t   ctrl_nxt;
    logic [1:0]           irqStatus_r;
    logic [1:0]           irqStatus_nxt;
    logic [1:0]           irqMask_r;
    logic [1:0]           irqMask_nxt;

    // Baud timer and output flops
    logic [RELOAD_W-1:0]  baudCnt_r;
    logic [RELOAD_W-1:0]  baudCnt_nxt;
    logic                 baudPulse_r;
    logic                 divClk_r;
    logic                 irq_r;
    logic [DATA_W-1:0]    rdData_r;
    logic [DATA_W-1:0]    rdData_nxt;

    // ========================================================================
    // Address decode
    wire hitBaudCtrl = regHit(regAddr, `UBG_OFS_BAUD_CONTROL);
    wire hitReload   = regHit(regAddr, `UBG_OFS_BAUD_RELOAD);
    wire hitFracCtrl = regHit(regAddr, `UBG_OFS_FRAC_CONTROL);
    wire hitIncr     = regHit(regAddr, `UBG_OFS_FRAC_INCREMENT);
    wire hitResult   = regHit(regAddr, `UBG_OFS_DIVIDER_RESULT);
    wire hitStatus   = regHit(regAddr, `UBG_OFS_IRQ_STATUS);
    wire hitMask     = regHit(regAddr, `UBG_OFS_IRQ_MASK);
    wire hitCount    = regHit(regAddr, `UBG_OFS_BAUD_COUNT);

    // Write strobes per register
    wire wrBaudCtrl  = regWrite && hitBaudCtrl;
    wire wrReload    = regWrite && hitReload;
    wire wrFracCtrl  = regWrite && hitFracCtrl;
    wire wrIncr      = regWrite && hitIncr;
    wire wrStatus    = regWrite && hitStatus;
    wire wrMask      = regWrite && hitMask;

    // ========================================================================
    // Mode decode of the divider stage
    ubg_pkg::ubg_fd_mode_t fdMode;

    assign fdMode = !ctrl_r.fractionDividerEnable    ? ubg_pkg::UBG_FD_OFF :
                    ctrl_r.fractionDividerModeSelect ? ubg_pkg::UBG_FD_NORMAL :
                                                       ubg_pkg::UBG_FD_FRACTION;

    // ========================================================================
    // Divider chain: prescaler then fractional/normal divider
    logic                 preTick;
    logic                 fracPulse;
    logic                 normPulse;
    logic [7:0]           fdResult;

    // Prescaler on the peripheral clock
    ubg_prescaler #(
        .SEL_W          (PRESEL_W)
    ) u_prescaler (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .prescaleSelect (ctrl_r.baudPrescaleSelect),
        .preTick        (preTick)
    );

    // Divider on prescaler ticks
    ubg_frac_divider #(
        .W              (8)
    ) u_frac_divider (
        .sys_clk        (sys_clk),
        .rst_n          (rst_n),
        .inTick         (preTick),
        .dividerEnable  (ctrl_r.fractionDividerEnable),
        .normalMode     (ctrl_r.fractionDividerModeSelect),
        .increment      (ctrl_r.fractionIncrement),
        .fracPulse      (fracPulse),
        .normPulse      (normPulse),
        .result         (fdResult)
    );

    // ========================================================================
    // Baud timer clocking and run decisions
    // Divider ticks when enabled, else prescaler
    wire timerTick = (fdMode == ubg_pkg::UBG_FD_OFF) ? preTick : fracPulse;
    // Normal mode stops the timer
    wire timerHalt = (fdMode == ubg_pkg::UBG_FD_NORMAL);
    // Run bit gates the timer only when not halted
    wire timerRun  = ctrl_r.baudTimerRun && !timerHalt;
    wire timerStep = timerRun && timerTick;
    wire timerZero = (baudCnt_r == '0);
    // Zero count: reload and pulse
    wire underflow = timerStep && timerZero;

    // Next count of the down-counter
    assign baudCnt_nxt = !timerStep ? baudCnt_r :
                         timerZero  ? ctrl_r.baudReloadField :
                                      baudCnt_r - RELOAD_W'(1);

    // ========================================================================
    // Event collection
    ubg_pkg::ubg_event_t  evt;

    assign evt.dividerOverflow = normPulse;
    assign evt.baudUnderflow   = underflow;

    // ========================================================================
    // Control register next values
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wrBaudCtrl) begin
            ctrl_nxt.baudTimerRun =
                regWrData[`UBG_BIT_BAUD_RUN];
            ctrl_nxt.baudPrescaleSelect =
                regWrData[`UBG_MSB_PRESCALE:`UBG_LSB_PRESCALE];
        end
        if (wrReload) begin
            ctrl_nxt.baudReloadField = regWrData[7:0];
        end
        if (wrFracCtrl) begin
            ctrl_nxt.fractionDividerEnable =
                regWrData[`UBG_BIT_FRAC_ENABLE];
            ctrl_nxt.fractionDividerModeSelect =
                regWrData[`UBG_BIT_FRAC_MODE];
        end
        if (wrIncr) begin
            ctrl_nxt.fractionIncrement = regWrData[7:0];
        end
    end

    // ========================================================================
    // Interrupt status and mask next values
    wire [1:0] evtBits = {evt.baudUnderflow, evt.dividerOverflow};
    wire [1:0] clrBits = wrStatus ? regWrData[1:0] : 2'h0;

    // Set beats clear: no event lost
    assign irqStatus_nxt = stickyNext(irqStatus_r, clrBits, evtBits);
    assign irqMask_nxt   = wrMask ? regWrData[1:0] : irqMask_r;

    // ========================================================================
    // Read data selection
    wire [DATA_W-1:0] rdBaudCtrl =
        ext8({4'h0, ctrl_r.baudPrescaleSelect, ctrl_r.baudTimerRun});
    wire [DATA_W-1:0] rdFracCtrl =
        ext8({6'h0, ctrl_r.fractionDividerModeSelect,
              ctrl_r.fractionDividerEnable});
    wire [DATA_W-1:0] rdStatus   = ext8({6'h0, irqStatus_r});
    wire [DATA_W-1:0] rdMask     = ext8({6'h0, irqMask_r});

    // Unmapped addresses read as zero; data valid one cycle after strobe
    assign rdData_nxt = !regRead    ? '0 :
                        hitBaudCtrl ? rdBaudCtrl :
                        hitReload   ? ext8(ctrl_r.baudReloadField) :
                        hitFracCtrl ? rdFracCtrl :
                        hitIncr     ? ext8(ctrl_r.fractionIncrement) :
                        hitResult   ? ext8(fdResult) :
                        hitStatus   ? rdStatus :
                        hitMask     ? rdMask :
                        hitCount    ? ext8(baudCnt_r) :
                                      '0;

    // ========================================================================
    // Control registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_r.baudTimerRun              <= `UBG_RST_RUN;
            ctrl_r.baudPrescaleSelect        <= `UBG_RST_PRESCALE;
            ctrl_r.baudReloadField           <= `UBG_RST_RELOAD;
            ctrl_r.fractionDividerEnable     <= `UBG_RST_FRAC_ENABLE;
            ctrl_r.fractionDividerModeSelect <= `UBG_RST_FRAC_MODE;
            ctrl_r.fractionIncrement         <= `UBG_RST_INCREMENT;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ========================================================================
    // Interrupt registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            irqStatus_r <= `UBG_RST_IRQ;
            irqMask_r   <= `UBG_RST_IRQ;
        end else begin
            irqStatus_r <= irqStatus_nxt;
            irqMask_r   <= irqMask_nxt;
        end
    end

    // ========================================================================
    // Baud timer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            baudCnt_r <= `UBG_RST_COUNT;
        end else begin
            baudCnt_r <= baudCnt_nxt;
        end
    end

    // ========================================================================
    // Output flops; pulses lag one cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            baudPulse_r <= 1'b0;
            divClk_r    <= 1'b0;
            irq_r       <= 1'b0;
            rdData_r    <= '0;
        end else begin
            baudPulse_r <= underflow;
            divClk_r    <= normPulse;
            irq_r       <= |(irqStatus_nxt & irqMask_nxt);
            rdData_r    <= rdData_nxt;
        end
    end

    // ========================================================================
    // Port drive
    assign regRdData    = rdData_r;
    assign baudPulse    = baudPulse_r;
    assign dividedClock = divClk_r;
    assign irq          = irq_r;

endmodule : ubg_baud_gen

/* rtl/ubg_map.svh */
// Register map of the baud-rate generator
`ifndef UBG_MAP_SVH
`define UBG_MAP_SVH

// ============================================================================
// Register offsets
`define UBG_OFS_BAUD_CONTROL     8'h00
`define UBG_OFS_BAUD_RELOAD      8'h04
`define UBG_OFS_FRAC_CONTROL     8'h08
`define UBG_OFS_FRAC_INCREMENT   8'h0c
`define UBG_OFS_DIVIDER_RESULT   8'h10
`define UBG_OFS_IRQ_STATUS       8'h14
`define UBG_OFS_IRQ_MASK         8'h18
`define UBG_OFS_BAUD_COUNT       8'h1c

// ============================================================================
// Field positions
`define UBG_BIT_BAUD_RUN         0
`define UBG_LSB_PRESCALE         1
`define UBG_MSB_PRESCALE         3
`define UBG_BIT_FRAC_ENABLE      0
`define UBG_BIT_FRAC_MODE        1
`define UBG_BIT_IRQ_OVERFLOW     0
`define UBG_BIT_IRQ_UNDERFLOW    1

// ============================================================================
// Reset values
`define UBG_RST_RUN              1'h0
`define UBG_RST_PRESCALE         3'h0
`define UBG_RST_RELOAD           8'h00
`define UBG_RST_FRAC_ENABLE      1'h0
`define UBG_RST_FRAC_MODE        1'h0
`define UBG_RST_INCREMENT        8'h00
`define UBG_RST_IRQ              2'h0
`define UBG_RST_COUNT            8'h00

`endif

/* rtl/ubg_pkg.sv */
// Types shared by the baud-rate generator modules
package ubg_pkg;

    // ========================================================================
    // Operating mode of the fractional divider stage
    typedef enum logic [1:0] {
        UBG_FD_OFF,
        UBG_FD_FRACTION,
        UBG_FD_NORMAL
    } ubg_fd_mode_t;

    // ========================================================================
    // Software controls steering the divider chain
    typedef struct packed {
        logic       baudTimerRun;
        logic [2:0] baudPrescaleSelect;
        logic [7:0] baudReloadField;
        logic       fractionDividerEnable;
        logic       fractionDividerModeSelect;
        logic [7:0] fractionIncrement;
    } ubg_ctrl_t;

    // ========================================================================
    // Events raised by the chain in one cycle
    typedef struct packed {
        logic dividerOverflow;
        logic baudUnderflow;
    } ubg_event_t;

endpackage : ubg_pkg

/* rtl/ubg_prescaler.sv */
// Power-of-two prescaler producing a one-cycle enable pulse
`timescale 1ns/1ns
module ubg_prescaler #(
    parameter int SEL_W = 3
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic [SEL_W-1:0] prescaleSelect,
    output logic                  preTick
);
    localparam int CNT_W = (1 << SEL_W) - 1;

    logic [CNT_W-1:0] preCnt_r;
    wire  [CNT_W-1:0] preMask = CNT_W'((1 << prescaleSelect) - 1);

    // One tick per 2^select cycles
    assign preTick = ((preCnt_r & preMask) == preMask);

    // Free-running; new select applies within a period
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            preCnt_r <= '0;
        end else begin
            preCnt_r <= preCnt_r + CNT_W'(1);
        end
    end

    generate
        if (SEL_W < 1 || SEL_W > 4) begin : g_bad_sel
            $error("ubg_prescaler: SEL_W must lie between 1 and 4");
        end
    endgenerate
endmodule : ubg_prescaler

/* rtl/ubg_frac_divider.sv */
// Fractional / normal divider stage following the prescaler
`timescale 1ns/1ns
module ubg_frac_divider #(
    parameter int W = 8
) (
    input  wire logic         sys_clk,
    input  wire logic         rst_n,
    input  wire logic         inTick,
    input  wire logic         dividerEnable,
    input  wire logic         normalMode,
    input  wire logic [W-1:0] increment,
    output logic              fracPulse,
    output logic              normPulse,
    output logic [W-1:0]      result
);
    logic [W-1:0] acc_r;
    logic [W-1:0] normCnt_r;

    wire          fracRun = dividerEnable && !normalMode && inTick;
    wire          normRun = dividerEnable && normalMode && inTick;
    wire  [W:0]   accSum  = {1'b0, acc_r} + {1'b0, increment};
    wire          normTop = (normCnt_r == {W{1'b1}});

    // Carry rate is increment/2^W
    assign fracPulse = fracRun && accSum[W];
    // One pulse per 2^W - increment ticks
    assign normPulse = normRun && normTop;
    assign result    = normalMode ? normCnt_r : acc_r;

    // Accumulator and reload counter, each in its mode
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            acc_r     <= '0;
            normCnt_r <= '0;
        end else begin
            if (fracRun) begin
                acc_r <= accSum[W-1:0];
            end
            if (normRun) begin
                normCnt_r <= normTop ? increment : normCnt_r + W'(1);
            end
        end
    end

    generate
        if (W != 8) begin : g_bad_w
            $error("ubg_frac_divider: only an 8-bit divider is supported");
        end
    endgenerate
endmodule : ubg_frac_divider

/* tb/ubg_baud_gen_properties.sv */
// Port-level concurrent checks of the baud-rate generator
`timescale 1ns/1ns
`include "ubg_map.svh"

module ubg_baud_gen_properties #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32
) (
    input wire logic              sys_clk,
    input wire logic              rst_n,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [DATA_W-1:0] regRdData,
    input wire logic              baudPulse,
    input wire logic              dividedClock,
    input wire logic              irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // ========================================================================
    // Shadow controls
    logic        runR, enR, modeR, wrDlyR, baudCleanR, divCleanR;
    logic [2:0]  selR;
    logic [7:0]  reloadR, incR;
    logic [1:0]  maskR;
    logic [31:0] baudGapR, divGapR;
    wire         wrBc  = regWrite && regAddr == `UBG_OFS_BAUD_CONTROL;
    wire         wrRl  = regWrite && regAddr == `UBG_OFS_BAUD_RELOAD;
    wire         wrFc  = regWrite && regAddr == `UBG_OFS_FRAC_CONTROL;
    wire         wrInc = regWrite && regAddr == `UBG_OFS_FRAC_INCREMENT;
    wire         wrMsk = regWrite && regAddr == `UBG_OFS_IRQ_MASK;
    // Writes near a pulse spoil its window
    wire         quiet = !regWrite && !wrDlyR;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {runR, selR, reloadR, enR, modeR, incR, maskR, wrDlyR} <= '0;
        end else begin
            wrDlyR <= regWrite;
            if (wrBc) {selR, runR} <= regWrData[3:0];
            if (wrRl) reloadR <= regWrData[7:0];
            if (wrFc) {modeR, enR} <= regWrData[1:0];
            if (wrInc) incR <= regWrData[7:0];
            if (wrMsk) maskR <= regWrData[1:0];
        end
    end

    // ========================================================================
    // Pulse gaps and setting stability
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            {baudGapR, divGapR, baudCleanR, divCleanR} <= '0;
        end else begin
            baudGapR   <= baudPulse ? 32'h1 : baudGapR + 32'h1;
            divGapR    <= dividedClock ? 32'h1 : divGapR + 32'h1;
            baudCleanR <= baudPulse ? quiet : baudCleanR && !regWrite;
            divCleanR  <= dividedClock ? quiet : divCleanR && !regWrite;
        end
    end

    // ========================================================================
    // Properties
    property p_rd_idle; !regRead |=> regRdData == '0; endproperty
    property p_run_stop; (!runR) [*2] |-> !baudPulse; endproperty
    property p_halt_normal; (enR && modeR) [*2] |-> !baudPulse; endproperty
    property p_baud_period; baudPulse && baudCleanR && runR && !enR
        |-> baudGapR == (({24'h0, reloadR} + 32'h1) << selR); endproperty
    property p_frac_zero; (enR && !modeR && incR == 8'h00) [*2] |-> !baudPulse; endproperty
    property p_divclk_normal; (!(enR && modeR)) [*2] |-> !dividedClock; endproperty
    property p_div_period; dividedClock && divCleanR && enR && modeR
        |-> divGapR == ((32'h100 - {24'h0, incR}) << selR); endproperty
    property p_irq_overflow; dividedClock && maskR[0] |-> irq; endproperty
    property p_irq_masked; maskR == 2'h0 |-> !irq; endproperty

    a_rd_idle: assert property (p_rd_idle) else $error("idle read data");
    a_run_stop: assert property (p_run_stop) else $error("pulse stopped");
    a_halt_normal: assert property (p_halt_normal) else $error("pulse halted");
    a_baud_period: assert property (p_baud_period) else $error("baud period");
    a_frac_zero: assert property (p_frac_zero) else $error("zero step pulse");
    a_divclk_normal: assert property (p_divclk_normal) else $error("divclk mode");
    a_div_period: assert property (p_div_period) else $error("div period");
    a_irq_overflow: assert property (p_irq_overflow) else $error("no irq");
    a_irq_masked: assert property (p_irq_masked) else $error("masked irq");

    c_baud: cover property (baudPulse && baudCleanR);
    c_div:  cover property (dividedClock && divCleanR);
    c_irq:  cover property (irq);
endmodule : ubg_baud_gen_properties

bind ubg_baud_gen ubg_baud_gen_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
    ubg_baud_gen_properties_i (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .baudPulse(baudPulse), .dividedClock(dividedClock), .irq(irq));

/* tb/ubg_serial_sink.sv */
// Serial-channel stand-in that consumes and tallies baud pulses
`timescale 1ns/1ns
module ubg_serial_sink (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic baudPulse,
    output int       pulseTotal
);
    // ========================================================================
    // One bit clock per high cycle; cannot stall
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pulseTotal <= 0;
        end else if (baudPulse) begin
            pulseTotal <= pulseTotal + 1;
        end
    end
endmodule : ubg_serial_sink

/* tb/ubg_baud_gen_test.sv */
// Self-checking bench of the baud-rate generator
`timescale 1ns/1ns
`include "ubg_map.svh"

module ubg_baud_gen_test;
    logic        sys_clk   = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  regAddr   = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWrite  = 1'b0;
    logic        regRead   = 1'b0;
    logic [31:0] regRdData, rd, d;
    logic        baudPulse, dividedClock, irq;
    logic [31:0] seed      = 32'h4a4b;
    logic [7:0]  inc;
    int          pulseTotal, gap, base, sel;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc       = 0;
    int          cfgQ[$]   = '{0, 0, 0, 2, 2, 5, 7, 1};
    logic [7:0]  rwAddr[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h18};
    logic [31:0] fMask[5]  = '{32'he, 32'hff, 32'h3, 32'hff, 32'h3};

    ubg_baud_gen ubg_baud_gen_i (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .baudPulse(baudPulse), .dividedClock(dividedClock), .irq(irq));
    ubg_serial_sink ubg_serial_sink_i (.sys_clk(sys_clk), .rst_n(rst_n),
        .baudPulse(baudPulse), .pulseTotal(pulseTotal));

    // ========================================================================
    // Clock and cycle count
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // ========================================================================
    // Register port strobes
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        regWrite  <= 1'b1;
        regAddr   <= a;
        regWrData <= v;
        @(posedge sys_clk);
        regWrite  <= 1'b0;
    endtask : wr

    task automatic rdreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge sys_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        v = regRdData;
    endtask : rdreg

    // Pulse gap; first pulse may mix old settings, so it is skipped
    task automatic pgap(input bit divSel, input int n, output int g);
        int k;
        int t0;
        k = -2;
        t0 = cyc;
        while (k < n && cyc - t0 < 5000) begin
            @(posedge sys_clk);
            #1;
            if ((divSel ? dividedClock : baudPulse) === 1'b1) begin
                k++;
                if (k == 0) base = cyc;
            end
        end
        g = cyc - base;
        if (k < n) bad_count++;
    endtask : pgap

    // The channel must see no pulse for a while
    task automatic silent();
        repeat (2) @(posedge sys_clk);
        #1;
        base = pulseTotal;
        repeat (300) @(posedge sys_clk);
        #1;
        check(pulseTotal - base, 0);
    endtask : silent

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // ========================================================================
    // Watchdog, well past the sequence length
    initial begin
        repeat (60000) @(posedge sys_clk);
        bad_count++;
        print_verdict();
    end

    // ========================================================================
    // Main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Reset values; writes to read-only/unmapped
        for (int a = 0; a < 9; a++) begin
            rdreg(8'(a * 4), rd);
            check(rd, 32'h0);
            if (a >= 4 && a != 5 && a != 6) wr(8'(a * 4), xs());
            rdreg(8'(a * 4), rd);
            check(rd, 32'h0);
        end
        // Random readback of the writable fields except the run bit
        for (int i = 0; i < 5; i++) begin
            d = xs() & fMask[i];
            wr(rwAddr[i], d);
            rdreg(rwAddr[i], rd);
            check(rd, d);
        end
        wr(`UBG_OFS_FRAC_CONTROL, 32'h0);
        wr(`UBG_OFS_IRQ_MASK, 32'h0);
        wr(`UBG_OFS_IRQ_STATUS, 32'h3);
        // Prescaler only: (reload+1) << sel cycles
        for (int i = 0; i < 8; i += 2) begin
            wr(`UBG_OFS_BAUD_RELOAD, cfgQ[i+1]);
            wr(`UBG_OFS_BAUD_CONTROL, (cfgQ[i] << 1) | 1);
            pgap(1'b0, 2, gap);
            check(gap, (2 * (cfgQ[i+1] + 1)) << cfgQ[i]);
        end
        wr(`UBG_OFS_BAUD_CONTROL, 32'h0);
        silent();
        // Fractional: inc carries per 256 ticks
        wr(`UBG_OFS_BAUD_RELOAD, 32'h0);
        wr(`UBG_OFS_FRAC_CONTROL, 32'h1);
        for (int i = 0; i < 3; i++) begin
            inc = (i == 0) ? 8'he6 : 8'(xs() | 8'h01);
            sel = (i == 2) ? 1 : 0;
            wr(`UBG_OFS_FRAC_INCREMENT, {24'h0, inc});
            wr(`UBG_OFS_BAUD_CONTROL, (sel << 1) | 1);
            pgap(1'b0, inc, gap);
            check(gap, 256 << sel);
        end
        wr(`UBG_OFS_FRAC_INCREMENT, 32'h0);
        silent();
        // Normal: timer halted, pulse every 256-inc ticks
        wr(`UBG_OFS_BAUD_CONTROL, 32'h1);
        wr(`UBG_OFS_FRAC_CONTROL, 32'h3);
        silent();
        for (int i = 0; i < 3; i++) begin
            inc = (i == 0) ? 8'hf0 : (i == 1) ? 8'h00 : 8'(xs());
            wr(`UBG_OFS_FRAC_INCREMENT, {24'h0, inc});
            pgap(1'b1, 1, gap);
            check(gap, 256 - inc);
            rdreg(`UBG_OFS_DIVIDER_RESULT, rd);
            check({31'h0, rd >= {24'h0, inc}}, 32'h1);
        end
        // Interrupt: raised on overflow, masked, cleared
        wr(`UBG_OFS_IRQ_MASK, 32'h1);
        pgap(1'b1, 0, gap);
        check({31'h0, irq}, 32'h1);
        rdreg(`UBG_OFS_IRQ_STATUS, rd);
        check(rd & 32'h1, 32'h1);
        wr(`UBG_OFS_IRQ_MASK, 32'h0);
        #1;
        check({31'h0, irq}, 32'h0);
        wr(`UBG_OFS_FRAC_CONTROL, 32'h0);
        wr(`UBG_OFS_IRQ_STATUS, 32'h1);
        rdreg(`UBG_OFS_IRQ_STATUS, rd);
        check(rd & 32'h1, 32'h0);
        wr(`UBG_OFS_IRQ_MASK, 32'h2);
        #1;
        check({31'h0, irq}, 32'h1);
        wr(`UBG_OFS_BAUD_CONTROL, 32'h0);
        wr(`UBG_OFS_IRQ_STATUS, 32'h3);
        #1;
        check({31'h0, irq}, 32'h0);
        print_verdict();
    end
endmodule : ubg_baud_gen_test
